// ---- rtl/fault_bank_pkg.sv ----
package fault_bank_pkg;

    // Register offsets on the management bus
    localparam logic [7:0] ADDR_SUPPLY = 8'hd4;
    localparam logic [7:0] ADDR_OCT = 8'hd5;
    localparam logic [7:0] ADDR_SERIOUS = 8'hd6;

    localparam logic [7:0] RESET_VAL = 8'h00;

    // Bits that latch until the host clears them
    localparam logic [7:0] SUPPLY_STICKY = 8'h30;
    localparam logic [7:0] OCT_STICKY = 8'ha7;
    localparam logic [7:0] SERIOUS_STICKY = 8'h14;

    // Field positions
    localparam int BIT_DRV_RAIL = 0;
    localparam int BIT_AUX_OV = 4;
    localparam int BIT_AUX_UV = 5;
    localparam int BIT_OC1 = 0;
    localparam int BIT_OC2 = 1;
    localparam int BIT_NOC = 2;
    localparam int BIT_CCL = 4;
    localparam int BIT_AVG = 5;
    localparam int BIT_THERM = 7;
    localparam int BIT_CONT_OC2 = 2;
    localparam int BIT_CONT_NOC = 4;

    // Consecutive cycles a fault may persist before the switches open
    localparam logic [2:0] PERSIST_CYCLES = 3'h3;

    localparam int NUM_PHASES = 4;

    typedef struct packed {
        logic drv_rail_out;
        logic aux_ov;
        logic aux_uv;
        logic [NUM_PHASES-1:0] oc1;
        logic [NUM_PHASES-1:0] oc2;
        logic [NUM_PHASES-1:0] negative_overcurrent;
        logic constant_current_loop;
        logic avg_fault;
        logic therm;
    } fault_in_t;

    typedef struct packed {
        logic valid;
        logic [NUM_PHASES-1:0] phases;
    } phase_loc_t;

endpackage

// ---- rtl/fault_status_flag_bank.sv ----
`timescale 1ns/1ps
module fault_status_flag_bank
    import fault_bank_pkg::*;
(
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_reset,
    // Comparator and protection levels
    input wire fault_in_t i_fault,
    // Byte register port
    input wire logic [7:0] i_reg_addr,
    input wire logic i_reg_wr,
    input wire logic [7:0] i_reg_wdata,
    input wire logic i_reg_rd,
    output logic [7:0] o_reg_rdata,
    output logic o_reg_rvalid,
    // Phase location feeds
    output phase_loc_t o_loc_one,
    output phase_loc_t o_loc_two,
    // Power stage
    output logic o_switches_off
);

    fault_in_t meta_q;
    fault_in_t fs_q;
    logic [7:0] sup_q;
    logic [7:0] oct_q;
    logic [7:0] ser_q;
    logic drv_live_q;
    logic ccl_live_q;
    logic [7:0] sup_set;
    logic [7:0] oct_set;
    logic [7:0] ser_set;
    logic [7:0] sup_clr;
    logic [7:0] oct_clr;
    logic [7:0] ser_clr;
    logic [7:0] sup_view;
    logic [7:0] oct_view;
    logic [7:0] rd_mux;
    logic [1:0] run;
    logic [1:0] cont_set;
    logic [7:0] rdata_q;
    logic rvalid_q;
    phase_loc_t loc_one_q;
    phase_loc_t loc_two_q;

    // Comparators are analog and free running, so the whole level set is synchronised
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            meta_q <= '0;
        end else begin
            meta_q <= i_fault;
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            fs_q <= '0;
        end else begin
            fs_q <= meta_q;
        end
    end

    // Indicators that follow their condition rather than latch
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            drv_live_q <= 1'b0;
            ccl_live_q <= 1'b0;
        end else begin
            drv_live_q <= fs_q.drv_rail_out;
            ccl_live_q <= fs_q.constant_current_loop;
        end
    end

    // Persistence counters for the two continuous faults
    assign run[0] = |fs_q.oc2;
    assign run[1] = |fs_q.negative_overcurrent;

    for (genvar g = 0; g < 2; g++) begin : g_persist
        logic [2:0] cnt_q;

        always_ff @(posedge i_clk) begin
            if (i_reset) begin
                cnt_q <= 3'h0;
            end else if (!run[g]) begin
                cnt_q <= 3'h0;
            end else if (cnt_q != PERSIST_CYCLES) begin
                cnt_q <= cnt_q + 3'h1;
            end
        end

        // Fires on the fourth consecutive cycle of the fault
        assign cont_set[g] = run[g] && (cnt_q == PERSIST_CYCLES);
    end

    // Events that raise flags
    always_comb begin
        sup_set = '0;
        sup_set[BIT_AUX_OV] = fs_q.aux_ov;
        sup_set[BIT_AUX_UV] = fs_q.aux_uv;
        oct_set = '0;
        oct_set[BIT_OC1] = |fs_q.oc1;
        oct_set[BIT_OC2] = |fs_q.oc2;
        oct_set[BIT_NOC] = |fs_q.negative_overcurrent;
        oct_set[BIT_AVG] = fs_q.avg_fault;
        oct_set[BIT_THERM] = fs_q.therm;
        ser_set = '0;
        ser_set[BIT_CONT_OC2] = cont_set[0];
        ser_set[BIT_CONT_NOC] = cont_set[1];
    end

    // Host clears by writing a one over the flag
    assign sup_clr = (i_reg_wr && i_reg_addr == ADDR_SUPPLY) ? i_reg_wdata : 8'h00;
    assign oct_clr = (i_reg_wr && i_reg_addr == ADDR_OCT) ? i_reg_wdata : 8'h00;
    assign ser_clr = (i_reg_wr && i_reg_addr == ADDR_SERIOUS) ? i_reg_wdata : 8'h00;

    // A fresh event in the clearing cycle wins, so no fault is lost
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            sup_q <= RESET_VAL;
        end else begin
            sup_q <= ((sup_q & ~sup_clr) | sup_set) & SUPPLY_STICKY;
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            oct_q <= RESET_VAL;
        end else begin
            oct_q <= ((oct_q & ~oct_clr) | oct_set) & OCT_STICKY;
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            ser_q <= RESET_VAL;
        end else begin
            ser_q <= ((ser_q & ~ser_clr) | ser_set) & SERIOUS_STICKY;
        end
    end

    // Switches stay open until the host has cleared both continuous flags
    assign o_switches_off = ser_q[BIT_CONT_OC2] | ser_q[BIT_CONT_NOC];

    // Phase capture toward the location registers
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            loc_one_q <= '0;
            loc_two_q <= '0;
        end else begin
            loc_one_q.valid <= |(fs_q.oc1 | fs_q.negative_overcurrent);
            loc_one_q.phases <= fs_q.oc1 | fs_q.negative_overcurrent;
            loc_two_q.valid <= |fs_q.oc2;
            loc_two_q.phases <= fs_q.oc2;
        end
    end

    assign o_loc_one = loc_one_q;
    assign o_loc_two = loc_two_q;

    // Read view merges the latched flags with the live indicators
    always_comb begin
        sup_view = sup_q;
        sup_view[BIT_DRV_RAIL] = drv_live_q;
        oct_view = oct_q;
        oct_view[BIT_CCL] = ccl_live_q;
        unique case (i_reg_addr)
            ADDR_SUPPLY: rd_mux = sup_view;
            ADDR_OCT: rd_mux = oct_view;
            ADDR_SERIOUS: rd_mux = ser_q;
            default: rd_mux = 8'h00;
        endcase
    end

    // Single byte per access, answered on the next edge
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            rdata_q <= 8'h00;
            rvalid_q <= 1'b0;
        end else begin
            rvalid_q <= i_reg_rd;
            if (i_reg_rd) begin
                rdata_q <= rd_mux;
            end
        end
    end

    assign o_reg_rdata = rdata_q;
    assign o_reg_rvalid = rvalid_q;

    // Checks
    default clocking cb @(posedge i_clk);
    endclocking

    default disable iff (i_reset);

    sequence s_oc2_run;
        run[0] [*4];
    endsequence

    sequence s_noc_run;
        run[1] [*4];
    endsequence

    // Started only off reset, so the cleared synchroniser is never held against a pin seen during reset
    property p_drv_rail;
        !i_reset |-> ##3 (sup_view[BIT_DRV_RAIL] == $past(i_fault.drv_rail_out, 3));
    endproperty
    a_drv_rail: assert property (p_drv_rail) else $error("rail health bit wrong");

    property p_aux_ov;
        fs_q.aux_ov |=> sup_q[BIT_AUX_OV];
    endproperty
    a_aux_ov: assert property (p_aux_ov) else $error("aux overvoltage not flagged");

    property p_aux_uv;
        fs_q.aux_uv |=> sup_q[BIT_AUX_UV];
    endproperty
    a_aux_uv: assert property (p_aux_uv) else $error("aux undervoltage not flagged");

    property p_oc1;
        (|fs_q.oc1) |=> oct_q[BIT_OC1] && loc_one_q.valid;
    endproperty
    a_oc1: assert property (p_oc1) else $error("level one overcurrent missed");

    property p_oc2;
        (|fs_q.oc2) |=> oct_q[BIT_OC2] && loc_two_q.valid && (loc_two_q.phases == $past(fs_q.oc2));
    endproperty
    a_oc2: assert property (p_oc2) else $error("level two overcurrent missed");

    property p_noc;
        (|fs_q.negative_overcurrent) |=> oct_q[BIT_NOC] && loc_one_q.valid;
    endproperty
    a_noc: assert property (p_noc) else $error("negative overcurrent missed");

    property p_ccl;
        !i_reset |-> ##3 (oct_view[BIT_CCL] == $past(i_fault.constant_current_loop, 3));
    endproperty
    a_ccl: assert property (p_ccl) else $error("current loop indicator wrong");

    property p_avg;
        fs_q.avg_fault |=> oct_q[BIT_AVG];
    endproperty
    a_avg: assert property (p_avg) else $error("average limit fault missed");

    property p_therm;
        fs_q.therm |=> oct_q[BIT_THERM];
    endproperty
    a_therm: assert property (p_therm) else $error("thermal fault missed");

    property p_cont_oc2;
        s_oc2_run |=> ser_q[BIT_CONT_OC2] && o_switches_off;
    endproperty
    a_cont_oc2: assert property (p_cont_oc2) else $error("continuous level two not acted on");

    property p_cont_noc;
        s_noc_run |=> ser_q[BIT_CONT_NOC] && o_switches_off;
    endproperty
    a_cont_noc: assert property (p_cont_noc) else $error("continuous negative not acted on");

    property p_early_off;
        !run[0] ##1 run[0] [*3] ##0 !run[1] [*4] ##0 !$past(o_switches_off) |=> !o_switches_off;
    endproperty
    a_early_off: assert property (p_early_off) else $error("switches opened too soon");

    property p_byte;
        i_reg_rd && (i_reg_addr == ADDR_SERIOUS) |=> o_reg_rvalid && ((o_reg_rdata & ~SERIOUS_STICKY) == 8'h00);
    endproperty
    a_byte: assert property (p_byte) else $error("reserved bits not zero");

    property p_sticky;
        oct_q[BIT_THERM] && !(i_reg_wr && i_reg_addr == ADDR_OCT && i_reg_wdata[BIT_THERM]) |=> oct_q[BIT_THERM];
    endproperty
    a_sticky: assert property (p_sticky) else $error("flag dropped without clear");

endmodule

// ---- verif/host_model.sv ----
`timescale 1ns/1ps
module host_model (
    // Clock
    input wire logic i_clk,
    // Byte register port toward the bank
    output logic [7:0] o_addr,
    output logic o_wr,
    output logic [7:0] o_wdata,
    output logic o_rd,
    input wire logic [7:0] i_rdata,
    input wire logic i_rvalid
);
    initial begin
        o_addr = 8'h00;
        o_wr = 1'b0;
        o_wdata = 8'h00;
        o_rd = 1'b0;
    end

    // One whole byte per access, strobe held up to the taking edge
    task automatic write_byte(input logic [7:0] addr, input logic [7:0] data);
        @(posedge i_clk);
        o_addr <= addr;
        o_wdata <= data;
        o_wr <= 1'b1;
        @(posedge i_clk);
        o_wr <= 1'b0;
        // Released data lines must not keep the last value
        o_wdata <= ~data;
    endtask

    // Answer stands one cycle only, so it is looked at just after the taking edge
    task automatic read_byte(input logic [7:0] addr, output logic [7:0] data, output logic ok);
        @(posedge i_clk);
        o_addr <= addr;
        o_rd <= 1'b1;
        @(posedge i_clk);
        o_rd <= 1'b0;
        #1;
        ok = (i_rvalid === 1'b1);
        data = i_rdata;
    endtask
endmodule

// ---- verif/fault_status_flag_bank_tb.sv ----
`timescale 1ns/1ps
module fault_status_flag_bank_tb;
    import fault_bank_pkg::*;
    logic i_clk;
    logic i_reset;
    fault_in_t i_fault;
    fault_in_t f;
    logic [7:0] reg_addr;
    logic [7:0] reg_wdata;
    logic [7:0] reg_rdata;
    logic [7:0] w;
    logic reg_wr;
    logic reg_rd;
    logic reg_rvalid;
    logic switches_off;
    phase_loc_t loc_one;
    phase_loc_t loc_two;
    logic [7:0] m [3];
    int miscompares = 0;
    int checks_done = 0;

    fault_status_flag_bank fault_status_flag_bank_i (.i_clk(i_clk), .i_reset(i_reset), .i_fault(i_fault),
        .i_reg_addr(reg_addr), .i_reg_wr(reg_wr), .i_reg_wdata(reg_wdata), .i_reg_rd(reg_rd),
        .o_reg_rdata(reg_rdata), .o_reg_rvalid(reg_rvalid), .o_loc_one(loc_one), .o_loc_two(loc_two),
        .o_switches_off(switches_off));
    host_model host_model_i (.i_clk(i_clk), .o_addr(reg_addr), .o_wr(reg_wr), .o_wdata(reg_wdata),
        .o_rd(reg_rd), .i_rdata(reg_rdata), .i_rvalid(reg_rvalid));

    initial begin
        i_clk = 1'b0;
        forever #50 i_clk = ~i_clk;
    end

    task automatic conclude();
        $display("Checks %0d, mismatches %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checks_done++;
        if (got !== exp) begin
            miscompares++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // Flags that latch once their condition has been seen
    function automatic logic [7:0] sticky_set(input int i, input fault_in_t x);
        case (i)
            0: return {2'b00, x.aux_uv, x.aux_ov, 4'h0};
            1: return {x.therm, 1'b0, x.avg_fault, 2'b00, |x.negative_overcurrent, |x.oc2, |x.oc1};
            default: return {3'b000, |x.negative_overcurrent, 1'b0, |x.oc2, 2'b00};
        endcase
    endfunction

    function automatic logic [7:0] live(input int i, input fault_in_t x);
        case (i)
            0: return {7'h00, x.drv_rail_out};
            1: return {3'b000, x.constant_current_loop, 4'h0};
            default: return 8'h00;
        endcase
    endfunction

    task automatic rd_chk(input logic [7:0] addr, input logic [7:0] exp);
        logic [7:0] d;
        logic ok;
        host_model_i.read_byte(addr, d, ok);
        chk({7'h00, ok}, 8'h01);
        chk(d, exp);
    endtask

    task automatic check_all(input fault_in_t x);
        for (int i = 0; i < 3; i++) begin
            rd_chk(8'hd4 + 8'(i), m[i] | live(i, x));
        end
        chk({3'b000, loc_one}, {3'b000, |(x.oc1 | x.negative_overcurrent), x.oc1 | x.negative_overcurrent});
        chk({3'b000, loc_two}, {3'b000, |x.oc2, x.oc2});
        chk({7'h00, switches_off}, {7'h00, |(m[2] & 8'h14)});
    endtask

    // Holds a fault pattern for a number of sampling edges, then lets it go
    task automatic pulse(input fault_in_t x, input int n);
        @(posedge i_clk);
        i_fault <= x;
        repeat (n) @(posedge i_clk);
        i_fault <= '0;
        repeat (8) @(posedge i_clk);
    endtask

    task automatic clear_all();
        for (int i = 0; i < 3; i++) begin
            host_model_i.write_byte(8'hd4 + 8'(i), 8'hff);
            m[i] = 8'h00;
        end
    endtask

    initial begin
        repeat (20000) @(posedge i_clk);
        miscompares++;
        conclude();
    end

    initial begin
        i_reset = 1'b1;
        i_fault = '0;
        for (int i = 0; i < 3; i++) m[i] = 8'h00;
        void'($urandom(80));
        repeat (2) @(posedge i_clk);
        i_reset <= 1'b0;
        check_all('0);
        host_model_i.write_byte(8'hd7, 8'hff);
        rd_chk(8'hd7, 8'h00);
        // Three cycles must not trip the switches, four must
        for (int k = 0; k < 4; k++) begin
            f = '0;
            if (k < 2) f.oc2 = 4'h1 << ($urandom % 4);
            else f.negative_overcurrent = 4'h1 << ($urandom % 4);
            pulse(f, 3 + k % 2);
            m[1] |= sticky_set(1, f);
            if (k % 2 == 1) m[2] |= sticky_set(2, f);
            check_all('0);
            clear_all();
        end
        for (int n = 0; n < 12; n++) begin
            f = fault_in_t'(18'($urandom));
            @(posedge i_clk);
            i_fault <= f;
            repeat (8) @(posedge i_clk);
            for (int i = 0; i < 3; i++) m[i] |= sticky_set(i, f);
            check_all(f);
            // A clear while the fault persists loses to the set
            for (int i = 0; i < 3; i++) begin
                w = 8'($urandom);
                host_model_i.write_byte(8'hd4 + 8'(i), w);
                m[i] = (m[i] & ~w) | sticky_set(i, f);
            end
            check_all(f);
            @(posedge i_clk);
            i_fault <= '0;
            repeat (8) @(posedge i_clk);
            check_all('0);
            clear_all();
            check_all('0);
        end
        // Every fault at once, then a reset in mid-run must drop all latched flags and the switch request
        f = fault_in_t'(18'h3ffff);
        @(posedge i_clk);
        i_fault <= f;
        repeat (8) @(posedge i_clk);
        for (int i = 0; i < 3; i++) m[i] |= sticky_set(i, f);
        check_all(f);
        @(posedge i_clk);
        i_reset <= 1'b1;
        i_fault <= '0;
        repeat (2) @(posedge i_clk);
        i_reset <= 1'b0;
        for (int i = 0; i < 3; i++) m[i] = 8'h00;
        check_all('0);
        conclude();
    end
endmodule
